// ===== dv/osf_sink.sv
// Downstream pipeline unit model that stalls two cycles in every four
module osf_sink (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic out_valid,
  output logic      out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_reg;
  // =====================================================================
  // Stall pattern
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_reg <= 2'h0;
    else cnt_reg <= cnt_reg + 2'h1;
  end
  assign out_ready = cnt_reg[1];
endmodule

// ===== dv/test_owner_stencil_fast_clear_test.sv
// Register and fragment tests for the fragment test stage
`include "osf_cfg.svh"
module test_owner_stencil_fast_clear_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, frag_valid, frag_ready, frag_active, depth_test_pass;
  logic        out_valid, out_ready, out_active, buffer_write_enable;
  logic        owner_test_pass, stencil_test_pass;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, stencil_value_message, local_read_stencil;
  logic [7:0]  local_read_frame_tag, source_read_stencil, source_read_frame_tag;
  logic [7:0]  buffer_write_stencil, buffer_write_frame_tag;
  logic [3:0]  s_axi_wstrb, local_read_owner_id, source_read_owner_id, buffer_write_owner_id;
  logic [1:0]  s_axi_bresp, s_axi_rresp, g_resp;
  logic [31:0] s_axi_wdata, s_axi_rdata, frag_depth, local_read_depth, source_read_depth;
  logic [31:0] buffer_write_depth, g_rd, g_dp;
  logic        g_act, g_we, g_own, g_stp;
  logic [7:0]  g_st, g_tag;
  logic [3:0]  g_oid;
  int          n_fail, samples_checked;
  // =====================================================================
  // Design and downstream model
  osf_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frag_valid, .frag_ready, .frag_active,
    .frag_depth, .depth_test_pass, .stencil_value_message, .local_read_depth,
    .local_read_stencil, .local_read_frame_tag, .local_read_owner_id, .source_read_depth,
    .source_read_stencil, .source_read_frame_tag, .source_read_owner_id, .out_valid,
    .out_ready, .out_active, .buffer_write_enable, .buffer_write_depth,
    .buffer_write_stencil, .buffer_write_frame_tag, .buffer_write_owner_id,
    .owner_test_pass, .stencil_test_pass);
  osf_sink u_sink (.aclk, .aresetn, .out_valid, .out_ready);
  always #12.5 aclk = ~aclk;
  // =====================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    g_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    g_rd = s_axi_rdata;
    g_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic frag(input logic [7:0] st, input logic [3:0] oid, input logic [7:0] tag,
                      input logic dp);
    @(posedge aclk);
    local_read_stencil <= st;
    local_read_owner_id <= oid;
    local_read_frame_tag <= tag;
    source_read_stencil <= ~st;
    source_read_owner_id <= ~oid;
    source_read_frame_tag <= ~tag;
    stencil_value_message <= st ^ 8'h5a;
    frag_depth <= {24'h0, st};
    local_read_depth <= {24'h0, tag};
    source_read_depth <= {28'h0, oid};
    depth_test_pass <= dp;
    frag_valid <= 1'b1;
    do @(posedge aclk); while (!frag_ready);
    frag_valid <= 1'b0;
    do @(posedge aclk); while (!(out_valid && out_ready));
    g_act = out_active;
    g_we = buffer_write_enable;
    g_own = owner_test_pass;
    g_stp = stencil_test_pass;
    g_st = buffer_write_stencil;
    g_tag = buffer_write_frame_tag;
    g_oid = buffer_write_owner_id;
    g_dp = buffer_write_depth;
  endtask
  // =====================================================================
  // Watchdog
  initial begin
    #(25 * 8000);
    n_fail++;
    close_out();
  end
  // =====================================================================
  // Tests
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, frag_valid, depth_test_pass, stencil_value_message} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, frag_depth, local_read_depth} = '0;
    {source_read_depth, local_read_stencil, local_read_frame_tag, local_read_owner_id} = '0;
    {source_read_stencil, source_read_frame_tag, source_read_owner_id} = '0;
    s_axi_wstrb = 4'hf;
    frag_active = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OSF_OFS_STMODE);
    chk("stmode", g_rd, 32'h0008_0000);
    rd(`OSF_OFS_STDATA);
    chk("stdata", g_rd, 32'h00ff_ff00);
    rd(8'h1c);
    chk("rresp", g_resp, 2'h2);
    wr(`OSF_OFS_STATUS, 32'h0000_ffff);
    chk("bresp", g_resp, 2'h2);
    frag(8'h33, 4'h3, 8'h00, 1'b1);
    chk("own_off", g_own, 1'b1);
    wr(`OSF_OFS_WINDOW, 32'h0000_0015);
    frag(8'h33, 4'h5, 8'h00, 1'b1);
    chk("own_eq", g_own, 1'b1);
    frag(8'h33, 4'h3, 8'h00, 1'b1);
    chk("own_ne", g_own, 1'b0);
    chk("we_ne", g_we, 1'b0);
    chk("oid", g_oid, 4'h3);
    wr(`OSF_OFS_WINDOW, 32'h0003_0015);
    frag(8'h33, 4'h3, 8'h00, 1'b1);
    chk("we_force", g_we, 1'b1);
    chk("oid_msg", g_oid, 4'h5);
    wr(`OSF_OFS_WINDOW, 32'h0001_0015);
    frag(8'h33, 4'h3, 8'h00, 1'b1);
    chk("oid_src", g_oid, 4'hc);
    chk("tag_src", g_tag, 8'hff);
    wr(`OSF_OFS_STDATA, 32'ha500_ff00);
    wr(`OSF_OFS_WINDOW, 32'h0000_c1c0);
    frag(8'h33, 4'h0, 8'h03, 1'b1);
    chk("st_clr", g_st, 8'ha5);
    chk("tag_clr", g_tag, 8'h07);
    chk("dp_clr", g_dp, 32'h0);
    frag(8'h33, 4'h0, 8'h07, 1'b1);
    chk("st_keep", g_st, 8'h33);
    chk("dp_keep", g_dp, 32'h07);
    wr(`OSF_OFS_WINDOW, 32'h0000_0000);
    wr(`OSF_OFS_DPMODE, 32'h0000_0003);
    wr(`OSF_OFS_STDATA, 32'h00ff_ff10);
    wr(`OSF_OFS_STMODE, 32'h0008_15c3);
    frag(8'h20, 4'h0, 8'h00, 1'b1);
    chk("st_dpp", g_st, 8'hdf);
    chk("dp_wr", g_dp, 32'h20);
    frag(8'h20, 4'h0, 8'h00, 1'b0);
    chk("st_dpf", g_st, 8'h21);
    frag(8'hff, 4'h0, 8'h00, 1'b0);
    chk("st_sat", g_st, 8'hff);
    frag(8'h08, 4'h0, 8'h00, 1'b1);
    chk("act_fail", {g_act, g_stp}, 2'h0);
    chk("dp_fail", g_dp, 32'h0);
    chk("st_fail", g_st, 8'h07);
    frag(8'h00, 4'h0, 8'h00, 1'b1);
    chk("st_decr", g_st, 8'h00);
    wr(`OSF_OFS_STDATA, 32'h000f_ff10);
    frag(8'h20, 4'h0, 8'h00, 1'b1);
    chk("st_wmsk", g_st, 8'h2f);
    wr(`OSF_OFS_STDATA, 32'h00ff_0f10);
    frag(8'h20, 4'h0, 8'h00, 1'b1);
    chk("st_cmsk", {g_stp, g_st}, 9'h01f);
    wr(`OSF_OFS_STDATA, 32'h00ff_ff10);
    wr(`OSF_OFS_STMODE, 32'h0004_15c3);
    frag(8'hf5, 4'h0, 8'h00, 1'b1);
    chk("st_w4", g_st, 8'h0a);
    wr(`OSF_OFS_STMODE, 32'h0008_35c3);
    frag(8'h20, 4'h0, 8'h00, 1'b1);
    chk("st_host", g_st, 8'h7a);
    wr(`OSF_OFS_STMODE, 32'h0008_75c3);
    frag(8'h20, 4'h0, 8'h00, 1'b1);
    chk("st_src", g_st, 8'h20);
    wr(`OSF_OFS_STMODE, 32'h0008_55c3);
    frag(8'h20, 4'h0, 8'h00, 1'b0);
    chk("st_srd", g_st, 8'hdf);
    wr(`OSF_OFS_STMODE, 32'h0008_011d);
    frag(8'h20, 4'h0, 8'h00, 1'b1);
    chk("st_zero", g_st, 8'h00);
    frag(8'h08, 4'h0, 8'h00, 1'b0);
    chk("st_repl", g_st, 8'h10);
    frag(8'h08, 4'h0, 8'h00, 1'b1);
    chk("st_kp", g_st, 8'h08);
    rd(`OSF_OFS_STATUS);
    chk("status", g_rd, 32'h0005_0015);
    close_out();
  end
endmodule

// ===== src/osf_cfg.svh
// Register offsets, field positions and reset values for the fragment test stage
`ifndef OSF_CFG_SVH
`define OSF_CFG_SVH
// =====================================================================
// Register offsets
`define OSF_OFS_WINDOW   8'h00
`define OSF_OFS_STMODE   8'h04
`define OSF_OFS_STDATA   8'h08
`define OSF_OFS_DPMODE   8'h0c
`define OSF_OFS_DPCLEAR  8'h10
`define OSF_OFS_STATUS   8'h14
// =====================================================================
// Window control fields
`define OSF_WIN_OWN_EN   0
`define OSF_WIN_OWN_NE   1
`define OSF_WIN_ID_LSB   2
`define OSF_WIN_TAG_LSB  6
`define OSF_WIN_DP_FC    14
`define OSF_WIN_ST_FC    15
`define OSF_WIN_FORCE    16
`define OSF_WIN_SRC_MSG  17
// Stencil control fields
`define OSF_ST_EN        0
`define OSF_ST_FUNC_LSB  1
`define OSF_ST_SFAIL_LSB 4
`define OSF_ST_DPF_LSB   7
`define OSF_ST_DPP_LSB   10
`define OSF_ST_SEL_LSB   13
`define OSF_ST_WID_LSB   16
// Stencil value fields
`define OSF_SD_REF_LSB   0
`define OSF_SD_CMSK_LSB  8
`define OSF_SD_WMSK_LSB  16
`define OSF_SD_CLR_LSB   24
// Depth control fields
`define OSF_DP_EN        0
`define OSF_DP_WMSK      1
// =====================================================================
// Reset values
`define OSF_RST_WINDOW   32'h0000_0000
`define OSF_RST_STMODE   32'h0008_0000
`define OSF_RST_STDATA   32'h00ff_ff00
`define OSF_RST_DPMODE   32'h0000_0002
`define OSF_RST_DPCLEAR  32'h0000_0000
`endif

// ===== src/osf_pkg.sv
// Types for the fragment test stage
package osf_pkg;
  typedef enum logic [2:0] {
    OSF_NEVER, OSF_LESS, OSF_EQUAL, OSF_LEQUAL,
    OSF_GREATER, OSF_NOTEQUAL, OSF_GEQUAL, OSF_ALWAYS
  } osf_cmp_t;
  typedef enum logic [2:0] {
    OSF_KEEP, OSF_ZERO, OSF_REPLACE, OSF_INCR, OSF_DECR, OSF_INVERT
  } osf_upd_t;
  typedef enum logic [1:0] {
    OSF_SEL_TEST, OSF_SEL_HOST, OSF_SEL_SRCREAD, OSF_SEL_SOURCE
  } osf_stsel_t;
  typedef enum logic [1:0] {
    OSF_RD_IDLE = 2'b01,
    OSF_RD_RESP = 2'b10
  } osf_rd_state_t;
endpackage

// ===== src/osf_top.sv
// Ownership, stencil and fast-clear test stage with AXI4-Lite registers
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`include "osf_cfg.svh"

// Functional notes
// - Ownership test disabled means pass
// - Compare 4-bit owner id with configured mode
// - Force bit always writes local buffer
// - Otherwise writes depend on test outcomes
// - Compare message frame tag with stored tag
// - Clear value replaces read on tag mismatch
// - Fast clear writes message frame tag
// - Clear-value writes ignore the field mask
// - Masks merge with read word
// - Frame tag output source selection
// - Owner id output source selection
// - Owner pass when disabled or compare passes
// - Stencil bits change only where mask set, except on fast clear or forced write
// - Compare mask gates both compare operands
// - Narrow stencil right-justified, high bits zero
// - Stencil disabled passes, unchanged unless clearing
// - Compare evaluates reference op source
// - Stencil fail: passive, sfail update, no depth
// - Stencil pass: depth-pass or depth-fail update
// - Six stencil update methods, saturating
// - Inputs and results masked to stencil width
// - Stencil from test logic or host message
// - Stencil may be unmodified source stencil
module osf_top import osf_pkg::*; #(
  parameter int DW = 32
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          frag_valid,
  output logic               frag_ready,
  input  wire logic          frag_active,
  input  wire logic [DW-1:0] frag_depth,
  input  wire logic          depth_test_pass,
  input  wire logic [7:0]    stencil_value_message,
  input  wire logic [DW-1:0] local_read_depth,
  input  wire logic [7:0]    local_read_stencil,
  input  wire logic [7:0]    local_read_frame_tag,
  input  wire logic [3:0]    local_read_owner_id,
  input  wire logic [DW-1:0] source_read_depth,
  input  wire logic [7:0]    source_read_stencil,
  input  wire logic [7:0]    source_read_frame_tag,
  input  wire logic [3:0]    source_read_owner_id,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic               out_active,
  output logic               buffer_write_enable,
  output logic [DW-1:0]      buffer_write_depth,
  output logic [7:0]         buffer_write_stencil,
  output logic [7:0]         buffer_write_frame_tag,
  output logic [3:0]         buffer_write_owner_id,
  output logic               owner_test_pass,
  output logic               stencil_test_pass
);
  // =====================================================================
  // Helper functions
  function automatic logic [7:0] width_mask(input logic [3:0] w);
    width_mask = (w >= 4'd8) ? 8'hff : 8'((9'h001 << w) - 9'h001);
  endfunction

  function automatic logic [7:0] st_update(input osf_upd_t m, input logic [7:0] src,
                                           input logic [7:0] rf, input logic [7:0] msk);
    case (m)
      OSF_KEEP:    st_update = src;
      OSF_ZERO:    st_update = 8'h00;
      OSF_REPLACE: st_update = rf;
      OSF_INCR:    st_update = (src == msk) ? msk : 8'(src + 8'h01);
      OSF_DECR:    st_update = (src == 8'h00) ? 8'h00 : 8'(src - 8'h01);
      OSF_INVERT:  st_update = ~src;
      default:     st_update = src;
    endcase
    st_update = st_update & msk;
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[1:0] == 2'b00) && (a <= `OSF_OFS_STATUS);
  endfunction

  // =====================================================================
  // Register file and AXI4-Lite slave
  logic [31:0] win_reg, win_next, stm_reg, stm_next, std_reg, std_next;
  logic [31:0] dpm_reg, dpm_next, dpc_reg, dpc_next, stat_reg, stat_next;
  logic        awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
  logic [7:0]  aw_reg, aw_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [3:0]  ws_reg, ws_next;
  logic [1:0]  br_reg, br_next, rr_reg, rr_next;
  osf_rd_state_t rst_reg, rst_next;
  logic        do_wr;

  function automatic logic [31:0] merge_be(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      o[i*8 +: 8] = be[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
    merge_be = o;
  endfunction

  always_comb begin
    awr_next = awr_reg;
    wr_next  = wr_reg;
    aw_next  = aw_reg;
    wd_next  = wd_reg;
    ws_next  = ws_reg;
    bv_next  = bv_reg;
    br_next  = br_reg;
    win_next = win_reg;
    stm_next = stm_reg;
    std_next = std_reg;
    dpm_next = dpm_reg;
    dpc_next = dpc_reg;
    if (s_axi_awvalid && !awr_reg && !bv_reg) begin
      awr_next = 1'b1;
      aw_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wr_reg && !bv_reg) begin
      wr_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    do_wr = awr_reg && wr_reg && !bv_reg;
    if (do_wr) begin
      awr_next = 1'b0;
      wr_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = (reg_hit(aw_reg) && aw_reg != `OSF_OFS_STATUS) ? 2'b00 : 2'b10;
      case (aw_reg)
        `OSF_OFS_WINDOW:  win_next = merge_be(win_reg, wd_reg, ws_reg);
        `OSF_OFS_STMODE:  stm_next = merge_be(stm_reg, wd_reg, ws_reg);
        `OSF_OFS_STDATA:  std_next = merge_be(std_reg, wd_reg, ws_reg);
        `OSF_OFS_DPMODE:  dpm_next = merge_be(dpm_reg, wd_reg, ws_reg);
        `OSF_OFS_DPCLEAR: dpc_next = merge_be(dpc_reg, wd_reg, ws_reg);
        default: ;
      endcase
    end
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
  end

  always_comb begin
    rst_next = rst_reg;
    rd_next  = rd_reg;
    rr_next  = rr_reg;
    case (rst_reg)
      OSF_RD_IDLE: begin
        if (s_axi_arvalid) begin
          rst_next = OSF_RD_RESP;
          rr_next  = reg_hit(s_axi_araddr) ? 2'b00 : 2'b10;
          case (s_axi_araddr)
            `OSF_OFS_WINDOW:  rd_next = win_reg;
            `OSF_OFS_STMODE:  rd_next = stm_reg;
            `OSF_OFS_STDATA:  rd_next = std_reg;
            `OSF_OFS_DPMODE:  rd_next = dpm_reg;
            `OSF_OFS_DPCLEAR: rd_next = dpc_reg;
            `OSF_OFS_STATUS:  rd_next = stat_reg;
            default:          rd_next = 32'h0000_0000;
          endcase
        end
      end
      OSF_RD_RESP: begin
        if (s_axi_rready) begin
          rst_next = OSF_RD_IDLE;
        end
      end
      default: rst_next = OSF_RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awr_reg <= 1'b0;
      wr_reg  <= 1'b0;
      aw_reg  <= 8'h00;
      wd_reg  <= 32'h0000_0000;
      ws_reg  <= 4'h0;
      bv_reg  <= 1'b0;
      br_reg  <= 2'b00;
      rst_reg <= OSF_RD_IDLE;
      rd_reg  <= 32'h0000_0000;
      rr_reg  <= 2'b00;
      win_reg <= `OSF_RST_WINDOW;
      stm_reg <= `OSF_RST_STMODE;
      std_reg <= `OSF_RST_STDATA;
      dpm_reg <= `OSF_RST_DPMODE;
      dpc_reg <= `OSF_RST_DPCLEAR;
    end else begin
      awr_reg <= awr_next;
      wr_reg  <= wr_next;
      aw_reg  <= aw_next;
      wd_reg  <= wd_next;
      ws_reg  <= ws_next;
      bv_reg  <= bv_next;
      br_reg  <= br_next;
      rst_reg <= rst_next;
      rd_reg  <= rd_next;
      rr_reg  <= rr_next;
      win_reg <= win_next;
      stm_reg <= stm_next;
      std_reg <= std_next;
      dpm_reg <= dpm_next;
      dpc_reg <= dpc_next;
    end
  end

  assign s_axi_awready = awr_reg;
  assign s_axi_wready  = wr_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = (rst_reg == OSF_RD_RESP);
  assign s_axi_rvalid  = (rst_reg == OSF_RD_RESP);
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;

  // =====================================================================
  // Configuration fields
  logic       own_en, own_ne, dp_fc, st_fc, force_wr, src_msg, st_en, dp_en, dp_wm;
  logic [3:0] own_id, st_wid;
  logic [7:0] cfg_tag, st_ref, st_cmask, st_wmask, st_clear, msk;
  osf_cmp_t   st_func;
  osf_stsel_t st_sel;
  assign own_en   = win_reg[`OSF_WIN_OWN_EN];
  assign own_ne   = win_reg[`OSF_WIN_OWN_NE];
  assign own_id   = win_reg[`OSF_WIN_ID_LSB +: 4];
  assign cfg_tag  = win_reg[`OSF_WIN_TAG_LSB +: 8];
  assign dp_fc    = win_reg[`OSF_WIN_DP_FC];
  assign st_fc    = win_reg[`OSF_WIN_ST_FC];
  assign force_wr = win_reg[`OSF_WIN_FORCE];
  assign src_msg  = win_reg[`OSF_WIN_SRC_MSG];
  assign st_en    = stm_reg[`OSF_ST_EN];
  assign st_func  = osf_cmp_t'(stm_reg[`OSF_ST_FUNC_LSB +: 3]);
  assign st_sel   = osf_stsel_t'(stm_reg[`OSF_ST_SEL_LSB +: 2]);
  assign st_wid   = stm_reg[`OSF_ST_WID_LSB +: 4];
  assign msk      = width_mask(st_wid);
  assign st_ref   = std_reg[`OSF_SD_REF_LSB +: 8] & msk;
  assign st_cmask = std_reg[`OSF_SD_CMSK_LSB +: 8];
  assign st_wmask = std_reg[`OSF_SD_WMSK_LSB +: 8];
  assign st_clear = std_reg[`OSF_SD_CLR_LSB +: 8];
  assign dp_en    = dpm_reg[`OSF_DP_EN];
  assign dp_wm    = dpm_reg[`OSF_DP_WMSK];

  // =====================================================================
  // Fragment tests
  logic          tag_eq, fc_st, fc_dp, own_pass, cmp_ok, st_pass;
  logic          st_upd, dp_upd, we, depth_ok;
  osf_upd_t      upd_m;
  logic [7:0]    src_st, a_cmp, b_cmp, test_val, sel_val, st_wm_eff, st_out;
  logic [DW-1:0] dp_val;

  always_comb begin
    tag_eq   = (cfg_tag == local_read_frame_tag);
    fc_st    = st_fc && !tag_eq;
    fc_dp    = dp_fc && !tag_eq;
    own_pass = !own_en || ((own_id == local_read_owner_id) ^ own_ne);
    src_st   = (fc_st ? st_clear : local_read_stencil) & msk;
    a_cmp    = st_ref & st_cmask;
    b_cmp    = src_st & st_cmask;
    case (st_func)
      OSF_NEVER:    cmp_ok = 1'b0;
      OSF_LESS:     cmp_ok = a_cmp < b_cmp;
      OSF_EQUAL:    cmp_ok = a_cmp == b_cmp;
      OSF_LEQUAL:   cmp_ok = a_cmp <= b_cmp;
      OSF_GREATER:  cmp_ok = a_cmp > b_cmp;
      OSF_NOTEQUAL: cmp_ok = a_cmp != b_cmp;
      OSF_GEQUAL:   cmp_ok = a_cmp >= b_cmp;
      default:      cmp_ok = 1'b1;
    endcase
    st_pass = !st_en || cmp_ok;
    depth_ok = !dp_en || depth_test_pass;
    if (!cmp_ok) begin
      upd_m = osf_upd_t'(stm_reg[`OSF_ST_SFAIL_LSB +: 3]);
    end else if (depth_ok) begin
      upd_m = osf_upd_t'(stm_reg[`OSF_ST_DPP_LSB +: 3]);
    end else begin
      upd_m = osf_upd_t'(stm_reg[`OSF_ST_DPF_LSB +: 3]);
    end
    test_val = st_en ? st_update(upd_m, src_st, st_ref, msk) : src_st;
    case (st_sel)
      OSF_SEL_TEST:    sel_val = test_val;
      OSF_SEL_HOST:    sel_val = stencil_value_message & msk;
      OSF_SEL_SRCREAD: sel_val = source_read_stencil & msk;
      OSF_SEL_SOURCE:  sel_val = src_st;
      default:         sel_val = test_val;
    endcase
    st_upd    = st_en || fc_st;
    st_wm_eff = fc_st ? 8'hff : st_wmask;
    st_out    = st_upd ? (((sel_val & st_wm_eff) | (local_read_stencil & ~st_wm_eff)) & msk)
                       : (local_read_stencil & msk);
    dp_upd = fc_dp || (dp_en && st_pass && depth_test_pass && dp_wm);
    if (dp_en && st_pass && depth_test_pass && dp_wm) begin
      dp_val = frag_depth;
    end else if (fc_dp) begin
      dp_val = dpc_reg[DW-1:0];
    end else begin
      dp_val = local_read_depth;
    end
    we = own_pass && (st_upd || dp_upd);
  end

  // =====================================================================
  // Output stage
  logic          ov_reg, ov_next, act_reg, act_next, we_reg, we_next;
  logic          op_reg, op_next, sp_reg, sp_next;
  logic [DW-1:0] dp_reg, dp_next;
  logic [7:0]    so_reg, so_next, tg_reg, tg_next;
  logic [3:0]    id_reg, id_next;
  logic          fire;

  assign fire = frag_valid && frag_ready;

  always_comb begin
    ov_next   = ov_reg;
    act_next  = act_reg;
    we_next   = we_reg;
    op_next   = op_reg;
    sp_next   = sp_reg;
    dp_next   = dp_reg;
    so_next   = so_reg;
    tg_next   = tg_reg;
    id_next   = id_reg;
    stat_next = stat_reg;
    if (out_valid && out_ready) begin
      ov_next = 1'b0;
    end
    if (fire) begin
      ov_next = 1'b1;
      op_next = own_pass;
      sp_next = st_pass;
      if (force_wr) begin
        act_next = frag_active;
        we_next  = 1'b1;
        dp_next  = src_msg ? frag_depth : source_read_depth;
        so_next  = src_msg ? stencil_value_message : source_read_stencil;
        tg_next  = src_msg ? cfg_tag : source_read_frame_tag;
        id_next  = src_msg ? own_id : source_read_owner_id;
      end else begin
        act_next = frag_active && own_pass && st_pass;
        we_next  = we;
        dp_next  = dp_val;
        so_next  = st_out;
        tg_next  = (dp_fc || st_fc) ? cfg_tag : local_read_frame_tag;
        id_next  = local_read_owner_id;
      end
      stat_next[15:0] = 16'(stat_reg[15:0] + 16'h0001);
      if (frag_active && !act_next) begin
        stat_next[31:16] = 16'(stat_reg[31:16] + 16'h0001);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ov_reg   <= 1'b0;
      act_reg  <= 1'b0;
      we_reg   <= 1'b0;
      op_reg   <= 1'b0;
      sp_reg   <= 1'b0;
      dp_reg   <= '0;
      so_reg   <= 8'h00;
      tg_reg   <= 8'h00;
      id_reg   <= 4'h0;
      stat_reg <= 32'h0000_0000;
    end else begin
      ov_reg   <= ov_next;
      act_reg  <= act_next;
      we_reg   <= we_next;
      op_reg   <= op_next;
      sp_reg   <= sp_next;
      dp_reg   <= dp_next;
      so_reg   <= so_next;
      tg_reg   <= tg_next;
      id_reg   <= id_next;
      stat_reg <= stat_next;
    end
  end

  assign frag_ready             = !ov_reg || out_ready;
  assign out_valid              = ov_reg;
  assign out_active             = act_reg;
  assign buffer_write_enable    = we_reg;
  assign buffer_write_depth     = dp_reg;
  assign buffer_write_stencil   = so_reg;
  assign buffer_write_frame_tag = tg_reg;
  assign buffer_write_owner_id  = id_reg;
  assign owner_test_pass        = op_reg;
  assign stencil_test_pass      = sp_reg;

  // =====================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_own_off;
    fire && !own_en |=> owner_test_pass;
  endproperty
  a_own_off: assert property (p_own_off) else $error("owner pass not set");
  property p_force;
    fire && force_wr |=> buffer_write_enable && out_valid;
  endproperty
  a_force: assert property (p_force) else $error("forced write missing");
  property p_own_fail;
    fire && !force_wr && !own_pass |=> !buffer_write_enable && !out_active;
  endproperty
  a_own_fail: assert property (p_own_fail) else $error("write on owner fail");
  property p_tag;
    fire && !force_wr && (dp_fc || st_fc) |=> buffer_write_frame_tag == $past(cfg_tag);
  endproperty
  a_tag: assert property (p_tag) else $error("frame tag not from window");
  property p_id;
    fire && !force_wr |=> buffer_write_owner_id == $past(local_read_owner_id);
  endproperty
  a_id: assert property (p_id) else $error("owner id not from read");
  property p_wmask;
    fire && !force_wr && !fc_st |=>
      ((buffer_write_stencil ^ ($past(local_read_stencil) & $past(msk)))
       & ~$past(st_wmask)) == 8'h00;
  endproperty
  a_wmask: assert property (p_wmask) else $error("masked stencil bit changed");
  property p_st_off;
    fire && !force_wr && !st_en && !fc_st |=>
      buffer_write_stencil == ($past(local_read_stencil) & $past(msk)) && stencil_test_pass;
  endproperty
  a_st_off: assert property (p_st_off) else $error("stencil changed while off");
  property p_st_fail;
    fire && !force_wr && st_en && !cmp_ok && !fc_dp |=>
      !out_active && buffer_write_depth == $past(local_read_depth);
  endproperty
  a_st_fail: assert property (p_st_fail) else $error("stencil fail not handled");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(buffer_write_stencil)
      && $stable(buffer_write_depth);
  endproperty
  a_hold: assert property (p_hold) else $error("output dropped under stall");

  c_force:   cover property (fire && force_wr);
  c_st_fail: cover property (fire && st_en && !cmp_ok);
  c_fast:    cover property (fire && fc_st && fc_dp);
  c_stall:   cover property (out_valid && !out_ready ##1 out_valid && out_ready);
endmodule
